// ---- rtl/byte_fifo.sv ----
`timescale 1ns/100ps
module byte_fifo #(
	parameter int width = 8,
	parameter int depth = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int aw = $clog2(depth);
	logic [width-1:0] mem [depth];
	logic [aw:0] wp_r;
	logic [aw:0] rp_r;
	logic [aw:0] rp_nxt;
	logic pop;
	logic push;

	// full when pointers differ only in the wrap bit
	assign in_ready = (wp_r[aw] == rp_r[aw]) || (wp_r[aw-1:0] != rp_r[aw-1:0]);
	assign push = in_valid && in_ready;
	assign pop = out_ready && out_valid;
	assign rp_nxt = pop ? rp_r + 1'b1 : rp_r;

	// write side
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_r <= '0;
		end else if (push) begin
			mem[wp_r[aw-1:0]] <= in_data;
			wp_r <= wp_r + 1'b1;
		end
	end

	// registered read: data comes from rp_nxt, so it changes with the pointer in the same cycle, valid follows it
	always_ff @(posedge clk) begin
		if (rst) begin
			rp_r <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			rp_r <= rp_nxt;
			out_valid <= (rp_nxt != wp_r) && !(pop && rp_nxt == wp_r);
			out_data <= mem[rp_nxt[aw-1:0]];
		end
	end
endmodule : byte_fifo

// ---- rtl/dbg_host.sv ----
`timescale 1ns/100ps
// host side of the single pin debug link: sends bytes from a fifo,
// receives replies, sends breaks and runs the unlock sequence
module dbg_host
	import dbg_host_pkg::*;
#(
	parameter int fifo_depth = 16,
	parameter int wait_cyc = unlock_wait_cyc,
	parameter int hold_cyc = post_reset_low_cyc
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [9:0] bit_div,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire byte_s tx_byte,
	input wire logic rx_expect,
	output logic rx_valid,
	output byte_s rx_byte,
	output logic rx_frame_err,
	output logic send_break,
	input wire logic break_req,
	input wire logic unlock_req,
	input wire logic dbg_entry_req,
	output logic busy,
	output logic collision,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	output logic reset_out,
	output logic reset_oe
);
	// ------------------------------------------------------------
	// line sampling
	// ------------------------------------------------------------
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic line_r;
	logic [3:0] oe_d_r;
	// three flops, level taken once the last two agree
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			line_r <= 1'b1;
		end else begin
			s1_r <= line_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				line_r <= s3_r;
			end
		end
	end

	// own drive delayed four cycles so it lines up with line_r; without it a
	// short bit reads the previous bit back and flags a false collision
	always_ff @(posedge clk) begin
		if (rst) begin
			oe_d_r <= '0;
		end else begin
			oe_d_r <= {oe_d_r[2:0], line_oe};
		end
	end

	// ------------------------------------------------------------
	// fifo of bytes to send
	// ------------------------------------------------------------
	logic f_valid;
	logic f_ready;
	byte_s f_data;
	byte_fifo #(.width(8), .depth(fifo_depth)) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_byte),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	// ------------------------------------------------------------
	// bit timer: clamp divisor into the legal range
	// ------------------------------------------------------------
	logic [9:0] div_r;
	logic [9:0] cnt_r;
	logic [31:0] long_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [2:0] key_idx_r;
	logic unlock_r;
	logic break_pend_r;
	logic unlock_pend_r;
	logic entry_pend_r;
	state_e st_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			div_r <= div_default;
		end else if (st_r == st_idle) begin
			if (bit_div < 10'(min_div)) begin
				div_r <= 10'(min_div);
			end else if (bit_div > 10'(max_div)) begin
				div_r <= 10'(max_div);
			end else begin
				div_r <= bit_div;
			end
		end
	end

	// key byte lookup for the unlock stream
	function automatic logic [7:0] key_byte(input logic [2:0] i);
		case (i)
			3'h0: key_byte = sync_char;
			3'h1: key_byte = key_b0;
			3'h2: key_byte = key_b1;
			3'h3: key_byte = key_b2;
			default: key_byte = key_b3;
		endcase
	endfunction : key_byte

	logic tick;
	logic half;
	assign tick = (cnt_r == div_r - 10'h001);
	assign half = (cnt_r == {1'b0, div_r[9:1]});
	assign f_ready = (st_r == st_idle) && !unlock_r && !break_pend_r && !unlock_pend_r
		&& !entry_pend_r && f_valid;

	// ------------------------------------------------------------
	// request latches; taken when idle
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			break_pend_r <= 1'b0;
			unlock_pend_r <= 1'b0;
			entry_pend_r <= 1'b0;
		end else begin
			if (break_req) begin
				break_pend_r <= 1'b1;
			end else if (st_r == st_break) begin
				break_pend_r <= 1'b0;
			end
			if (unlock_req) begin
				unlock_pend_r <= 1'b1;
			end else if (st_r == st_rst_low) begin
				unlock_pend_r <= 1'b0;
			end
			if (dbg_entry_req) begin
				entry_pend_r <= 1'b1;
			end else if (st_r == st_rst_hold) begin
				entry_pend_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// main sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= st_idle;
			cnt_r <= '0;
			long_r <= '0;
			bit_r <= '0;
			sh_r <= '0;
			key_idx_r <= '0;
			unlock_r <= 1'b0;
			line_out <= 1'b0;
			line_oe <= 1'b0;
			reset_out <= 1'b0;
			reset_oe <= 1'b0;
			rx_valid <= 1'b0;
			rx_byte <= '0;
			rx_frame_err <= 1'b0;
			send_break <= 1'b0;
			collision <= 1'b0;
			busy <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			rx_frame_err <= 1'b0;
			collision <= 1'b0;
			send_break <= 1'b0;
			busy <= (st_r != st_idle);
			cnt_r <= tick ? 10'h000 : cnt_r + 10'h001;
			case (st_r)
				st_idle: begin
					cnt_r <= '0;
					line_oe <= 1'b0;
					if (break_pend_r) begin
						st_r <= st_break;
						long_r <= '0;
						line_oe <= 1'b1;
					end else if (unlock_pend_r) begin
						st_r <= st_rst_low;
						long_r <= '0;
						reset_oe <= 1'b1;
						key_idx_r <= '0;
					end else if (entry_pend_r) begin
						st_r <= st_rst_hold;
						long_r <= '0;
						reset_oe <= 1'b1;
						line_oe <= 1'b1;
					end else if (unlock_r) begin
						sh_r <= key_byte(key_idx_r);
						st_r <= st_start;
						line_oe <= 1'b1;
					end else if (f_valid) begin
						sh_r <= f_data.data;
						st_r <= st_start;
						line_oe <= 1'b1;
					end
				end
				st_start: if (tick) begin
					bit_r <= '0;
					line_oe <= !sh_r[0];
					st_r <= st_data;
				end
				st_data: begin
					// released bit read back low means someone else drives
					if (half && !oe_d_r[3] && !line_r) begin
						collision <= 1'b1;
					end
					if (tick) begin
						sh_r <= {1'b0, sh_r[7:1]};
						if (bit_r == 4'h7) begin
							line_oe <= 1'b0;
							st_r <= st_stop;
						end else begin
							bit_r <= bit_r + 4'h1;
							line_oe <= !sh_r[1];
						end
					end
				end
				st_stop: if (tick) begin
					if (unlock_r) begin
						if (key_idx_r == 3'h4) begin
							unlock_r <= 1'b0;
							reset_oe <= 1'b0;
						end
						key_idx_r <= key_idx_r + 3'h1;
						st_r <= st_idle;
					end else begin
						// reply may start at once, so watch immediately
						st_r <= rx_expect ? st_rx_wait : st_idle;
						long_r <= '0;
					end
				end
				st_rx_wait: begin
					cnt_r <= '0;
					long_r <= long_r + 32'h1;
					if (!line_r) begin
						st_r <= st_rx_bits;
						bit_r <= '0;
						long_r <= '0;
					end else if (long_r >= 32'(div_r) * 32'(max_div)) begin
						st_r <= st_idle; // no answer
					end
				end
				st_rx_bits: begin
					long_r <= line_r ? 32'h0 : long_r + 32'h1;
					if (long_r >= 32'(div_r) * 32'(break_bits)) begin
						send_break <= 1'b1;
						st_r <= st_idle;
					end else if (half && bit_r != 4'h0) begin
						sh_r <= {line_r, sh_r[7:1]};
					end
					if (tick) begin
						if (bit_r == 4'h8) begin
							st_r <= st_rx_stop;
						end else begin
							bit_r <= bit_r + 4'h1;
						end
					end
				end
				st_rx_stop: begin
					// nine low bits reach into the stop bit, so the break is caught here
					long_r <= line_r ? 32'h0 : long_r + 32'h1;
					if (long_r >= 32'(div_r) * 32'(break_bits)) begin
						send_break <= 1'b1;
						st_r <= st_idle;
					end else if (half) begin
						rx_byte <= sh_r;
						rx_valid <= line_r;
						rx_frame_err <= !line_r;
						st_r <= st_idle;
					end
				end
				st_break: begin
					// break held well past nine bits so the device resyncs
					long_r <= long_r + 32'h1;
					if (long_r >= 32'(div_r) * 32'(2 * break_bits) - 32'h1) begin
						line_oe <= 1'b0;
						st_r <= st_idle;
					end
				end
				st_rst_low: begin
					long_r <= long_r + 32'h1;
					if (long_r >= 32'(wait_cyc)) begin
						unlock_r <= 1'b1;
						st_r <= st_idle;
					end
				end
				st_rst_hold: begin
					long_r <= long_r + 32'h1;
					if (long_r == 32'(hold_cyc) - 32'h1) begin
						reset_oe <= 1'b0;
					end
					if (long_r >= 32'(2 * hold_cyc) - 32'h1) begin
						line_oe <= 1'b0;
						st_r <= st_idle;
					end
				end
				default: st_r <= st_idle;
			endcase
		end
	end
endmodule : dbg_host

// ---- rtl/dbg_host_pkg.sv ----
// What this block does
// - one shared open-drain line, half duplex
// - start, eight data lsb first, stop
// - host never drives stop bit high
// - first character after reset is 0x80
// - bit time between clk/512 and clk/4
// - nine low bits form a break
// - device held reset while break lasts
// - host holds pin low 5000 cycles more
// - unlock: hold reset, wait, sync, key bytes
// - after unlock, resync and write 0x80
package dbg_host_pkg;
	localparam int clk_mhz = 50;
	localparam logic [7:0] sync_char = 8'h80;
	localparam logic [7:0] key_b0 = 8'heb;
	localparam logic [7:0] key_b1 = 8'h5a;
	localparam logic [7:0] key_b2 = 8'h70;
	localparam logic [7:0] key_b3 = 8'hcd;
	localparam logic [7:0] debug_mode_value = 8'h80;
	localparam int unlock_wait_us = 5000;
	localparam int unlock_wait_cyc = unlock_wait_us * clk_mhz;
	localparam int post_reset_low_cyc = 5000;
	localparam int break_bits = 9;
	localparam int min_div = 4;
	localparam int max_div = 512;
	localparam logic [9:0] div_default = 10'h1b2;

	typedef struct packed {
		logic [7:0] data;
	} byte_s;

	typedef enum logic [3:0] {
		st_idle = 4'h0,
		st_start = 4'h1,
		st_data = 4'h2,
		st_stop = 4'h3,
		st_break = 4'h4,
		st_rx_wait = 4'h5,
		st_rx_bits = 4'h6,
		st_rx_stop = 4'h7,
		st_rst_low = 4'h8,
		st_rst_hold = 4'h9
	} state_e;
endpackage : dbg_host_pkg

// ---- test/dbg_device_model.sv ----
`timescale 1ns/100ps
// ----
// device end of the debug line
// ----
module dbg_device_model (
	input wire logic clk,
	input wire logic line,
	input wire logic [9:0] div,
	input wire logic [7:0] reply,
	input wire logic reply_en,
	input wire logic brk_en,
	input wire logic bad_stop,
	output logic oe,
	output logic got,
	output logic [7:0] data
);
	int i;
	// only ever pulls low, stop bit is a release unless bad_stop holds it low
	task automatic send(input logic [7:0] b);
		oe <= 1;
		for (int k = 0; k < 9; k++) begin
			repeat (div) @(posedge clk);
			oe <= (k < 8) ? !b[k] : bad_stop;
		end
		repeat (div) @(posedge clk);
		oe <= 0;
	endtask : send
	// receive, then answer at the stop bit's end with no gap
	initial begin
		oe = 0;
		got = 0;
		data = 0;
		forever begin
			@(negedge line);
			repeat (div / 2) @(posedge clk);
			for (i = 0; i < 9; i++) begin
				repeat (div) @(posedge clk);
				if (i < 8) data[i] = line;
			end
			// a low stop bit is a bad frame and is dropped
			if (line) begin
				got <= 1;
				@(posedge clk);
				got <= 0;
				repeat (div / 2 - 1) @(posedge clk);
				if (brk_en) begin
					oe <= 1;
					repeat (40 * div) @(posedge clk);
					oe <= 0;
				end else if (reply_en) send(reply);
			end
		end
	end
endmodule : dbg_device_model

// ---- test/dbg_host_properties.sv ----
`timescale 1ns/100ps
// ----
// port checks
// ----
module dbg_host_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic busy,
	input wire logic line_oe,
	input wire logic line_out,
	input wire logic reset_oe,
	input wire logic reset_out,
	input wire logic rx_valid,
	input wire logic rx_frame_err,
	input wire logic send_break,
	input wire logic collision
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// open drain pins never drive high
	chk_pull_low: assert property (line_out == 0 && reset_out == 0)
		else $error("pin driven high");
	chk_oe_busy: assert property (line_oe && $past(line_oe) |-> busy)
		else $error("line pulled while idle");
	chk_start_len: assert property ($rose(line_oe) |-> line_oe[*4])
		else $error("low bit shorter than four clocks");
	chk_rx_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("reply strobe too long");
	chk_err_excl: assert property (!(rx_valid && rx_frame_err))
		else $error("good and bad reply together");
	chk_brk_pulse: assert property (send_break |=> !send_break)
		else $error("break flag too long");
	chk_col_pulse: assert property (collision |=> !collision)
		else $error("collision flag too long");
	chk_rst_idle: assert property ($fell(rst) |-> !line_oe && !reset_oe)
		else $error("pins busy after reset");
	chk_hold_line: assert property ($fell(reset_oe) && line_oe |-> line_oe[*8])
		else $error("pin released with reset");
	chk_reset_len: assert property ($rose(reset_oe) |-> reset_oe[*8])
		else $error("reset pin released too soon");
	cover property ($rose(reset_oe));
	cover property (rx_valid);
	cover property (send_break);
endmodule : dbg_host_properties
bind dbg_host dbg_host_properties chk (.clk, .rst, .busy, .line_oe, .line_out,
	.reset_oe, .reset_out, .rx_valid, .rx_frame_err, .send_break, .collision);

// ---- test/single_pin_debug_serial_port_bench.sv ----
`timescale 1ns/100ps
module single_pin_debug_serial_port_bench
	import dbg_host_pkg::*;
();
	logic clk = 0, rst = 1, tx_valid = 0, rx_expect = 0, reply_en = 0, brk_en = 0;
	logic break_req = 0, unlock_req = 0, dbg_entry_req = 0, bad_stop = 0, jam = 0;
	logic [9:0] bit_div = 10'h008;
	logic [7:0] reply = 8'h00;
	byte_s tx_byte = '0;
	byte_s rx_byte;
	logic tx_ready, rx_valid, rx_frame_err, send_break, busy, collision;
	logic line_out, line_oe, reset_out, reset_oe, dev_oe, got;
	logic [7:0] dev_data;
	logic [31:0] seed = 59;
	logic [7:0] exp_q[$], rx_q[$];
	int n_fail = 0, checks_done = 0, cyc = 0, n_acc = 0, brk_cnt = 0, col_cnt = 0, ferr_cnt = 0;
	int run = 0, run_len = 0, rrun = 0, rrun_len = 0;
	int divs[3] = '{4, 9, 512};
	// pull-up holds the line high when nobody pulls it
	wire line = !(line_oe || dev_oe || jam);

	dbg_host #(.wait_cyc(200), .hold_cyc(50)) DUT (.clk, .rst, .bit_div, .tx_valid,
		.tx_ready, .tx_byte, .rx_expect, .rx_valid, .rx_byte, .rx_frame_err, .send_break,
		.break_req, .unlock_req, .dbg_entry_req, .busy, .collision, .line_in(line),
		.line_out, .line_oe, .reset_out, .reset_oe);
	dbg_device_model dev (.clk, .line, .div(bit_div), .reply, .reply_en, .brk_en,
		.bad_stop, .oe(dev_oe), .got, .data(dev_data));

	initial forever #10 clk = ~clk;

	// ----
	// tasks
	// ----
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (e !== s) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask : cmp_byte
	task automatic cmp_val(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (e !== s) begin
			n_fail++;
			$display("unexpected %s exp %0d got %0d", n, e, s);
		end
	endtask : cmp_val
	// push, pulse and idle start and end two ns after a rising edge
	task automatic push(input logic [7:0] b);
		tx_valid = 1;
		tx_byte.data = b;
		@(posedge clk);
		while (tx_ready !== 1) @(posedge clk);
		#2 exp_q.push_back(b);
	endtask : push
	task automatic pulse(ref logic s);
		s = 1;
		@(posedge clk);
		#2 s = 0;
		repeat (2) @(posedge clk); // busy lags a cycle
		#2;
	endtask : pulse
	task automatic idle(input string n);
		tx_valid = 0;
		do @(posedge clk); while (exp_q.size() || rx_q.size() || busy !== 0 || dev_oe);
		#2 $display("test %s done", n);
	endtask : idle
	task final_report();
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// ----
	// result watcher, pulse lengths and timeout
	// ----
	always @(posedge clk) begin
		if (line_oe) run++;
		else if (run) begin
			run_len = run;
			run = 0;
		end
		if (reset_oe) rrun++;
		else if (rrun) begin
			rrun_len = rrun;
			rrun = 0;
		end
		if (send_break === 1) brk_cnt++;
		if (collision === 1) col_cnt++;
		if (rx_frame_err === 1) ferr_cnt++;
		if (got === 1) cmp_byte("device byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, dev_data);
		if (rx_valid === 1) cmp_byte("reply", rx_q.size() ? rx_q.pop_front() : 8'hxx, rx_byte.data);
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			final_report();
		end
	end

	// ----
	// main sequence
	// ----
	initial begin
		repeat (3) @(posedge clk);
		#2 rst = 0;
		// sync then a byte at both ends of the rate range
		foreach (divs[k]) begin
			bit_div = 10'(divs[k]);
			push(sync_char);
			push(rnd());
			idle("rate");
		end
		bit_div = 10'h008;
		// write every cycle while the far side drains one frame at a time
		tx_valid = 1;
		repeat (24) begin
			tx_byte.data = rnd();
			@(posedge clk);
			if (tx_ready === 1) begin
				n_acc++;
				exp_q.push_back(tx_byte.data);
			end
			#2;
		end
		cmp_val("accepted", 17, n_acc);
		idle("fifo");
		reply = rnd();
		reply_en = 1;
		rx_expect = 1;
		rx_q.push_back(reply);
		push(rnd());
		idle("reply");
		// reply closed by a low stop bit: reported, not taken
		reply = rnd() | 8'h80;
		bad_stop = 1;
		push(rnd());
		idle("bad stop");
		cmp_val("frame errors", 1, ferr_cnt);
		bad_stop = 0;
		reply_en = 0;
		brk_en = 1;
		push(rnd());
		idle("device break");
		cmp_val("break seen", 1, brk_cnt);
		brk_en = 0;
		rx_expect = 0;
		pulse(break_req);
		idle("host break");
		cmp_val("break length", 18 * 8, run_len);
		exp_q = '{sync_char, key_b0, key_b1, key_b2, key_b3};
		pulse(unlock_req);
		idle("unlock");
		cmp_val("unlock hold", 1, rrun_len > 200);
		push(sync_char);
		push(debug_mode_value);
		idle("resync");
		pulse(dbg_entry_req);
		idle("entry");
		cmp_val("reset hold", 50, rrun_len);
		cmp_val("pin hold", 100, run_len);
		cmp_val("no collision", 0, col_cnt);
		// far end pulls the line under a released byte
		push(8'hff);
		tx_valid = 0;
		void'(exp_q.pop_back()); // jammed frame ends low, the far end drops it
		repeat (40) @(posedge clk);
		#2 jam = 1;
		repeat (100) @(posedge clk);
		#2 jam = 0;
		idle("collision");
		cmp_val("collision", 1, col_cnt > 0);
		final_report();
	end
endmodule : single_pin_debug_serial_port_bench
